// ---- comparator_output_irq_logic.sv ----
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "comparator_regs.svh"

// What this block does
// - pin carries comparator result, unsynchronised
// - direction bit still enables pin driver
// - bit 4 inverts comparator output
// - aux bit 1 chooses timer gate source
// - sync mode latches b on timer fall
// - latch uses prescaled timer clock when used
// - timer counts on rising clock edge
// - output change sets flag bits 4:3
// - flags cleared by writing zero, one sets
// - irq needs enable, peripheral and global
// - flag set on mismatch edge, not level
// - primary control access reloads mismatch register
// - unrefreshed mismatch: no irq on return
// - refreshed mismatch: irq again on return
// - change during control read still sets flag
// - reset restores registers, comparators disabled
// - ladder: 32 levels from code and range
// - disabled ladder, code 0, range: ground
// - aux register mirrors both results
// - mirror read leaves mismatch registers alone
// - gate select 0 uses synced comparator b
// - sync mode off bypasses timer latch
module comparator_output_irq_logic
    import comparator_pkg::*;
#(
    parameter int ADR_W = 12
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // classic wishbone slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    // analog comparator raw outputs, asynchronous
    input  wire logic             cmp_a_raw,
    input  wire logic             cmp_b_raw,
    output logic                  cmp_a_on,
    output logic                  cmp_b_on,
    // pins shared with the port logic
    input  wire logic             port_direction_a,
    input  wire logic             port_direction_b,
    input  wire logic             port_data_a,
    input  wire logic             port_data_b,
    output logic                  pin_a_out,
    output logic                  pin_a_oe_n,
    output logic                  pin_b_out,
    output logic                  pin_b_oe_n,
    // timer side
    input  wire logic             timer_gate_pin,
    input  wire logic             timer_prescaler_used,
    input  wire logic             timer_clk_rise,
    input  wire logic             timer_clk_fall,
    input  wire logic             prescaled_rise,
    input  wire logic             prescaled_fall,
    output logic                  timer_gate,
    output logic                  timer_inc,
    output logic                  cmp_b_result_synced,
    // cpu interrupt request
    output logic                  cmp_irq,
    // reference ladder control
    output logic [3:0]            ladder_code,
    output logic                  ladder_range_sel,
    output logic [4:0]            ladder_reference_level,
    output logic                  ladder_powered,
    output logic                  ladder_ground,
    output logic                  ladder_pin_out_en,
    output logic                  cmp_a_ladder_en,
    output logic                  cmp_b_ladder_en
);

    //**********************************************************
    // state
    //**********************************************************
    state_t     st_r;
    state_t     st_nxt;

    logic [7:0] index;
    logic       req;
    logic       commit;
    logic       wr;
    logic       rd;
    logic [7:0] wbyte;
    logic [1:0] result;
    logic [1:0] mismatch;
    logic [1:0] raw_res;
    logic       tick_fall;
    logic       tick_rise;

    assign index = wb_adr_i[9:2];
    assign req   = wb_cyc_i & wb_stb_i;
    // writes and mismatch reloads land on the edge that ends the ack cycle
    assign commit = req & st_r.ack;
    assign wr     = commit & wb_we_i & wb_sel_i[0];
    assign rd     = commit & ~wb_we_i;
    assign wbyte  = wb_dat_i[7:0];

    //**********************************************************
    // comparator results
    //**********************************************************
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            // disabled comparator reads as zero
            result[i]   = (st_r.sync2[i] ^ st_r.ctrl[i].invert) & st_r.ctrl[i].on;
            raw_res[i]  = (((i == 0) ? cmp_a_raw : cmp_b_raw) ^ st_r.ctrl[i].invert)
                          & st_r.ctrl[i].on;
            mismatch[i] = result[i] ^ st_r.mismatch_ref[i];
        end
    end

    // pin path is combinational on purpose: no clock delay on the result
    assign pin_a_out  = st_r.ctrl[0].pin_en ? raw_res[0] : port_data_a;
    assign pin_b_out  = st_r.ctrl[1].pin_en ? raw_res[1] : port_data_b;
    assign pin_a_oe_n = port_direction_a;
    assign pin_b_oe_n = port_direction_b;

    //**********************************************************
    // timer gate and synchronous mode
    //**********************************************************
    assign tick_fall = timer_prescaler_used ? prescaled_fall : timer_clk_fall;
    assign tick_rise = timer_prescaler_used ? prescaled_rise : timer_clk_rise;

    assign cmp_b_result_synced = st_r.sync_mode ? st_r.b_latched : result[1];
    assign timer_gate = st_r.gate_sel ? st_r.gpin2 : cmp_b_result_synced;
    // counting on the opposite edge from the latch avoids a gate/count race
    assign timer_inc  = tick_rise & timer_gate;

    //**********************************************************
    // interrupt and ladder outputs
    //**********************************************************
    assign cmp_irq = (|(st_r.flag & st_r.irq_en)) & st_r.periph_en & st_r.global_en;

    assign ladder_code       = st_r.ladder[`LAD_CODE_MSB:0];
    assign ladder_range_sel  = st_r.ladder[`LAD_RANGE_BIT];
    assign ladder_pin_out_en = st_r.ref_pin_out_en;
    assign cmp_a_ladder_en   = st_r.ladder[`LAD_A_EN_BIT];
    assign cmp_b_ladder_en   = st_r.ladder[`LAD_B_EN_BIT];
    // tap: range 1 gives code*vdd/24, range 0 gives vdd/4 + code*vdd/32
    assign ladder_reference_level = {ladder_range_sel, ladder_code};
    assign ladder_powered = cmp_a_ladder_en | cmp_b_ladder_en | ladder_pin_out_en;
    assign ladder_ground  = ~ladder_powered & ladder_range_sel
                            & (ladder_code == 4'h0);

    assign cmp_a_on = st_r.ctrl[0].on;
    assign cmp_b_on = st_r.ctrl[1].on;
    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = {24'h000000, st_r.rdata};

    //**********************************************************
    // next state
    //**********************************************************
    always_comb begin
        logic [7:0] rv;
        logic [1:0] flag_w;
        rv     = 8'h00;
        flag_w = st_r.flag;
        st_nxt = st_r;

        // synchronisers; first stage feeds only the second
        st_nxt.sync1 = {cmp_b_raw, cmp_a_raw};
        st_nxt.sync2 = st_r.sync1;
        st_nxt.gpin1 = timer_gate_pin;
        st_nxt.gpin2 = st_r.gpin1;

        if (tick_fall && st_r.sync_mode) begin
            st_nxt.b_latched = result[1];
        end

        // ---- register read data, taken before ack ----
        case (index)
            `IDX_CMP_A_PRIMARY, `IDX_CMP_B_PRIMARY: begin
                rv[`PRI_ON_BIT]     = st_r.ctrl[index[0]].on;
                rv[`PRI_RESULT_BIT] = result[index[0]];
                rv[`PRI_PIN_EN_BIT] = st_r.ctrl[index[0]].pin_en;
                rv[`PRI_INVERT_BIT] = st_r.ctrl[index[0]].invert;
            end
            `IDX_CMP_AUX: begin
                rv[`AUX_A_COPY_BIT]   = result[0];
                rv[`AUX_B_COPY_BIT]   = result[1];
                rv[`AUX_GATE_SEL_BIT] = st_r.gate_sel;
                rv[`AUX_SYNC_BIT]     = st_r.sync_mode;
            end
            `IDX_PERIPH_FLAG:   rv[`FLAG_MSB:`FLAG_LSB] = st_r.flag;
            `IDX_PERIPH_ENABLE: rv[`FLAG_MSB:`FLAG_LSB] = st_r.irq_en;
            `IDX_IRQ_CONTROL: begin
                rv[`IRQ_GLOBAL_BIT] = st_r.global_en;
                rv[`IRQ_PERIPH_BIT] = st_r.periph_en;
            end
            `IDX_REF_OUTPUT: rv[`REF_PIN_OUT_BIT] = st_r.ref_pin_out_en;
            `IDX_LADDER:     rv = st_r.ladder & `LAD_WMASK;
            default:         rv = 8'h00;
        endcase

        st_nxt.ack = req & ~st_r.ack;
        if (req && !st_r.ack) begin
            st_nxt.rdata = wb_we_i ? 8'h00 : rv;
        end

        // ---- register writes ----
        if (wr) begin
            case (index)
                `IDX_CMP_A_PRIMARY, `IDX_CMP_B_PRIMARY: begin
                    st_nxt.ctrl[index[0]].on     = wbyte[`PRI_ON_BIT];
                    st_nxt.ctrl[index[0]].pin_en = wbyte[`PRI_PIN_EN_BIT];
                    st_nxt.ctrl[index[0]].invert = wbyte[`PRI_INVERT_BIT];
                end
                `IDX_CMP_AUX: begin
                    st_nxt.gate_sel  = wbyte[`AUX_GATE_SEL_BIT];
                    st_nxt.sync_mode = wbyte[`AUX_SYNC_BIT];
                end
                `IDX_PERIPH_FLAG:   flag_w = wbyte[`FLAG_MSB:`FLAG_LSB];
                `IDX_PERIPH_ENABLE: st_nxt.irq_en = wbyte[`FLAG_MSB:`FLAG_LSB];
                `IDX_IRQ_CONTROL: begin
                    st_nxt.global_en = wbyte[`IRQ_GLOBAL_BIT];
                    st_nxt.periph_en = wbyte[`IRQ_PERIPH_BIT];
                end
                `IDX_REF_OUTPUT: st_nxt.ref_pin_out_en = wbyte[`REF_PIN_OUT_BIT];
                `IDX_LADDER:     st_nxt.ladder = wbyte & `LAD_WMASK;
                default: ;
            endcase
        end

        // ---- change detection ----
        for (int i = 0; i < 2; i++) begin
            logic hit;
            hit = 1'b0;
            if ((wr || rd) && index[7:1] == `IDX_CMP_A_PRIMARY >> 1 && index[0] == i[0]) begin
                hit = 1'b1;
            end
            // edge, not level: a held mismatch sets the flag only once
            if (mismatch[i] && !st_r.mismatch_d[i]) begin
                flag_w[i] = 1'b1;
            end
            // a change landing on the reload cycle still sets the flag before the reload absorbs it
            if (hit) begin
                st_nxt.mismatch_ref[i] = result[i];
                st_nxt.mismatch_d[i]   = 1'b0;
            end else begin
                st_nxt.mismatch_d[i]   = mismatch[i];
            end
        end
        // hardware set outranks a software clear in the same cycle
        st_nxt.flag = flag_w;
    end

    //**********************************************************
    // registers
    //**********************************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r          <= '0;
            st_r.gate_sel <= `AUX_GATE_SEL_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule : comparator_output_irq_logic

// ---- comparator_regs.svh ----
`ifndef COMPARATOR_REGS_SVH
`define COMPARATOR_REGS_SVH

// register indices; byte address is four times the index
`define IDX_CMP_A_PRIMARY   8'h90
`define IDX_CMP_B_PRIMARY   8'h91
`define IDX_CMP_AUX         8'h92
`define IDX_PERIPH_FLAG     8'h93
`define IDX_PERIPH_ENABLE   8'h94
`define IDX_IRQ_CONTROL     8'h95
`define IDX_REF_OUTPUT      8'h98
`define IDX_LADDER          8'h99

// primary control fields
`define PRI_ON_BIT          7
`define PRI_RESULT_BIT      6
`define PRI_PIN_EN_BIT      5
`define PRI_INVERT_BIT      4

// auxiliary control fields
`define AUX_A_COPY_BIT      7
`define AUX_B_COPY_BIT      6
`define AUX_GATE_SEL_BIT    1
`define AUX_SYNC_BIT        0
`define AUX_GATE_SEL_RESET  1'b1

// flag / enable registers: comparator a at bit 3, b at bit 4
`define FLAG_LSB            3
`define FLAG_MSB            4

// irq control fields
`define IRQ_GLOBAL_BIT      7
`define IRQ_PERIPH_BIT      6

// reference output control field
`define REF_PIN_OUT_BIT     1

// ladder control fields
`define LAD_A_EN_BIT        7
`define LAD_B_EN_BIT        6
`define LAD_RANGE_BIT       5
`define LAD_CODE_MSB        3
`define LAD_RESET           8'h00
`define LAD_WMASK           8'hEF

`endif

// ---- comparator_pkg.sv ----
package comparator_pkg;

    // one comparator's software control
    typedef struct packed {
        logic on;
        logic pin_en;
        logic invert;
    } cmp_ctrl_t;

    typedef struct packed {
        logic [1:0] sync1;        // first synchroniser stage, comparator b at [1]
        logic [1:0] sync2;        // second synchroniser stage
        logic [1:0] mismatch_ref; // mismatch registers
        logic [1:0] mismatch_d;   // last mismatch level, for edge detection
        cmp_ctrl_t  [1:0] ctrl;
        logic       gate_sel;
        logic       sync_mode;
        logic       b_latched;
        logic       gpin1;
        logic       gpin2;
        logic [1:0] flag;
        logic [1:0] irq_en;
        logic       global_en;
        logic       periph_en;
        logic       ref_pin_out_en;
        logic [7:0] ladder;
        logic       ack;
        logic [7:0] rdata;
    } state_t;

endpackage : comparator_pkg

// ---- cmp_partner.sv ----
`timescale 1ns/1ps
// ****************
// analog side and timer clock source
// ****************
module cmp_partner (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic a_lvl,
    input  wire logic b_lvl,
    output logic      raw_a,
    output logic      raw_b,
    output logic      t_rise,
    output logic      t_fall,
    output logic      p_rise,
    output logic      p_fall
);
    logic [3:0] cnt_r;
    // timer clock is clk/8, prescaled one clk/16; edges come as one-cycle pulses
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) cnt_r <= 4'h0;
        else cnt_r <= cnt_r + 4'h1;
    end
    assign t_rise = cnt_r[2:0] == 3'h0;
    assign t_fall = cnt_r[2:0] == 3'h4;
    assign p_rise = cnt_r == 4'h0;
    assign p_fall = cnt_r == 4'h8;
    assign raw_a  = a_lvl;
    assign raw_b  = b_lvl;
endmodule : cmp_partner

// ---- comparator_output_irq_logic_assertions.sv ----
`timescale 1ns/1ps
module cmp_checker (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic        port_direction_a,
    input wire logic        pin_a_oe_n,
    input wire logic        timer_prescaler_used,
    input wire logic        timer_clk_rise,
    input wire logic        prescaled_rise,
    input wire logic        timer_gate,
    input wire logic        timer_inc,
    input wire logic        cmp_a_on,
    input wire logic        cmp_irq,
    input wire logic [3:0]  ladder_code,
    input wire logic        ladder_range_sel,
    input wire logic [4:0]  ladder_reference_level,
    input wire logic        ladder_ground,
    input wire logic        ladder_pin_out_en,
    input wire logic        cmp_a_ladder_en,
    input wire logic        cmp_b_ladder_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack not a one-cycle answer");
    property p_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper read data not zero");
    property p_oe; pin_a_oe_n == port_direction_a; endproperty
    a_oe: assert property (p_oe) else $error("pin enable not from direction");
    property p_gate; timer_inc |-> timer_gate; endproperty
    a_gate: assert property (p_gate) else $error("count while gate low");
    property p_edge;
        timer_inc |-> (timer_prescaler_used ? prescaled_rise : timer_clk_rise);
    endproperty
    a_edge: assert property (p_edge) else $error("count off rising edge");
    property p_lvl; ladder_reference_level == {ladder_range_sel, ladder_code}; endproperty
    a_lvl: assert property (p_lvl) else $error("ladder level wrong");
    property p_gnd;
        !ladder_pin_out_en && !cmp_a_ladder_en && !cmp_b_ladder_en && ladder_range_sel
            && ladder_code == 4'h0 |-> ladder_ground;
    endproperty
    a_gnd: assert property (p_gnd) else $error("ladder not grounded");
    property p_rst; $fell(sys_rst) |-> !cmp_a_on && !cmp_irq && !wb_ack_o; endproperty
    a_rst: assert property (p_rst) else $error("state after reset");
    c_irq: cover property (cmp_irq);
    c_inc: cover property (timer_inc);
    c_gnd: cover property (ladder_ground);
endmodule : cmp_checker
bind comparator_output_irq_logic cmp_checker chk_i (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .wb_dat_o, .port_direction_a, .pin_a_oe_n, .timer_prescaler_used,
    .timer_clk_rise, .prescaled_rise, .timer_gate, .timer_inc, .cmp_a_on, .cmp_irq,
    .ladder_code, .ladder_range_sel, .ladder_reference_level, .ladder_ground,
    .ladder_pin_out_en, .cmp_a_ladder_en, .cmp_b_ladder_en);

// ---- comparator_output_irq_logic_test.sv ----
`timescale 1ns/1ps
module comparator_output_irq_logic_test;
    import comparator_pkg::*;
    logic clk, sys_rst, cyc, stb, we, ack, a_lvl, b_lvl, dir, gpin, pre, ra, rb;
    logic tr, tf, pr, pf, pin_a, gate, bsync, irq;
    logic [11:0] adr;
    logic [31:0] dat, rdat;
    logic [7:0]  q, d;
    logic [4:0]  lvl;
    int miscompares, num_checks, cycles, seed, k;
    cmp_partner far (.clk, .sys_rst, .a_lvl, .b_lvl, .raw_a(ra), .raw_b(rb),
        .t_rise(tr), .t_fall(tf), .p_rise(pr), .p_fall(pf));
    comparator_output_irq_logic uut (.clk, .sys_rst, .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .cmp_a_raw(ra), .cmp_b_raw(rb), .cmp_a_on(), .cmp_b_on(),
        .port_direction_a(dir), .port_direction_b(dir), .port_data_a(1'b0),
        .port_data_b(1'b1), .pin_a_out(pin_a), .pin_a_oe_n(), .pin_b_out(),
        .pin_b_oe_n(), .timer_gate_pin(gpin), .timer_prescaler_used(pre),
        .timer_clk_rise(tr), .timer_clk_fall(tf), .prescaled_rise(pr),
        .prescaled_fall(pf), .timer_gate(gate), .timer_inc(), .cmp_b_result_synced(bsync),
        .cmp_irq(irq), .ladder_code(), .ladder_range_sel(), .ladder_reference_level(lvl),
        .ladder_powered(), .ladder_ground(), .ladder_pin_out_en(), .cmp_a_ladder_en(),
        .cmp_b_ladder_en());
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task bus(input logic w, input logic [7:0] i, input logic [7:0] v);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= {2'h0, i, 2'h0};
        dat <= {24'h0, v};
        // ack is looked at mid-cycle where it is settled; the request stands to the next rise
        do @(negedge clk); while (ack !== 1'b1 && n++ < 50);
        if (ack !== 1'b1) miscompares++;
        q = rdat[7:0];
        @(posedge clk);
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : bus
    task rd(input logic [7:0] i, input logic [7:0] exp);
        bus(1'b0, i, 8'h00);
        chk(q, exp);
    endtask : rd
    // results lag the raw level by up to two clocks through the synchroniser
    task settle;
        repeat (5) @(posedge clk);
        @(negedge clk);
    endtask : settle
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        seed = 7233;
        {cyc, stb, we, a_lvl, b_lvl, dir, gpin, pre} = 8'h00;
        adr = 12'h000;
        dat = 32'h0;
        sys_rst = 1'b1;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        rd(8'h99, 8'h00);
        rd(8'h92, 8'h02);
        rd(8'h90, 8'h00);
        rd(8'h42, 8'h00);
        for (k = 0; k < 32; k++) begin
            d = $random(seed);
            d = {d[7:6], k[4], d[4], k[3:0]};
            bus(1'b1, 8'h99, d);
            rd(8'h99, d & 8'hEF);
            chk(lvl, k[4:0]);
        end
        bus(1'b1, 8'h90, 8'hB0);
        settle();
        chk(pin_a, 1'b1);
        rd(8'h90, 8'hF0);
        bus(1'b1, 8'h90, 8'h80);
        rd(8'h90, 8'h80);
        bus(1'b1, 8'h93, 8'h00);
        a_lvl <= 1'b1;
        settle();
        rd(8'h93, 8'h08);
        rd(8'h92, 8'h82);
        bus(1'b1, 8'h94, 8'h08);
        bus(1'b1, 8'h95, 8'hC0);
        settle();
        chk(irq, 1'b1);
        bus(1'b1, 8'h95, 8'h80);
        settle();
        chk(irq, 1'b0);
        bus(1'b1, 8'h93, 8'h00);
        a_lvl <= 1'b0;
        settle();
        rd(8'h93, 8'h00);
        a_lvl <= 1'b1;
        settle();
        bus(1'b1, 8'h93, 8'h00);
        rd(8'h90, 8'hC0);
        a_lvl <= 1'b0;
        settle();
        rd(8'h93, 8'h08);
        bus(1'b1, 8'h93, 8'h10);
        rd(8'h93, 8'h10);
        gpin <= 1'b1;
        settle();
        chk(gate, 1'b1);
        bus(1'b1, 8'h92, 8'h00);
        bus(1'b1, 8'h91, 8'h80);
        b_lvl <= 1'b1;
        settle();
        chk(gate, 1'b1);
        bus(1'b1, 8'h92, 8'h01);
        pre <= 1'b1;
        repeat (40) @(posedge clk);
        @(negedge clk);
        chk(bsync, 1'b1);
        @(posedge clk);
        b_lvl <= 1'b0;
        repeat (40) @(posedge clk);
        @(negedge clk);
        chk(bsync, 1'b0);
        final_report();
    end
endmodule : comparator_output_irq_logic_test
